// [src/elcl_top.sv]
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module elcl_top #(
    parameter int MS_CYCLES_P = elcl_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [elcl_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control sources
    input wire elcl_pkg::elcl_val_t src_value,
    input wire elcl_pkg::elcl_val_t math_min,
    input wire elcl_pkg::elcl_val_t math_max,
    input wire logic [3:0][31:0] cond_arg,
    input wire elcl_pkg::elcl_val_t set_level,
    input wire elcl_pkg::elcl_val_t reset_level,
    // Function block outputs
    output elcl_pkg::elcl_val_t tbl_out,
    output elcl_pkg::elcl_val_t tbl_min,
    output elcl_pkg::elcl_val_t tbl_max,
    output logic cond_out,
    output logic latch_out
);
    import elcl_pkg::*;

    localparam int MS_W = $clog2(MS_CYCLES_P);

    logic axis_mode;
    logic x_src_math;
    logic [3:0] arg_sel;
    logic [2:0] op1;
    logic [2:0] op2;
    logic [1:0] op3;
    logic [15:0] set_min;
    logic [15:0] set_max;
    logic [15:0] rst_min;
    logic [15:0] rst_max;
    elcl_val_t pt_x [NPT];
    elcl_val_t pt_y [NPT];
    logic [1:0] pt_kind [NPT];
    elcl_state_e state;
    logic [3:0] cl_idx;
    elcl_val_t rng_lo;
    elcl_val_t rng_hi;
    elcl_val_t elapsed_ms;
    logic [MS_W-1:0] ms_cnt;
    elcl_val_t y_base;
    logic ramp_neg;
    logic set_on;
    logic rst_on;
    logic rst_seen;
    logic [31:0] rd_data;

    elcl_div_if div_bus();

    elcl_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .bus(div_bus)
    );

    // APB decode
    wire logic apb_wr = psel & penable & pready & pwrite;
    wire logic [3:0] pt_idx = paddr[IDX_MSB:IDX_LSB];
    wire logic [1:0] region = paddr[REG_MSB:REG_LSB];
    wire logic pt_ok = (pt_idx <= PT_LAST);
    wire logic hit_x = pt_ok && (region == REG_X);
    wire logic hit_y = pt_ok && (region == REG_Y);
    wire logic hit_k = pt_ok && (region == REG_K);
    wire logic hit_ctrl = (paddr == ADDR_CTRL);
    wire logic hit_ops = (paddr == ADDR_OPS);
    wire logic hit_sthr = (paddr == ADDR_SET_THR);
    wire logic hit_rthr = (paddr == ADDR_RST_THR);
    wire logic hit_ro = (paddr == ADDR_STATUS) | (paddr == ADDR_TBL_OUT) |
        (paddr == ADDR_TBL_MIN) | (paddr == ADDR_TBL_MAX) | (paddr == ADDR_ELAPSED);
    wire logic mapped = hit_x | hit_y | hit_k | hit_ctrl | hit_ops | hit_sthr |
        hit_rthr | hit_ro;
    wire logic [1:0] wr_op3 = pwdata[OPS_OP3_LSB +: 2];

    // X range limits and write clamping
    wire elcl_val_t xmin_eff = x_src_math ? math_min : X_LIMIT_MIN;
    wire elcl_val_t xmax_eff = x_src_math ? math_max : X_LIMIT_MAX;
    wire logic range_changed = (xmin_eff != rng_lo) | (xmax_eff != rng_hi);
    wire logic clamp_hold = (state == ST_CLAMP) | range_changed;
    wire elcl_val_t wr_lo = (pt_idx == 4'h0) ? xmin_eff : pt_x[pt_idx - 4'h1];
    wire elcl_val_t wr_hi = (pt_idx == PT_LAST) ? xmax_eff : pt_x[pt_idx + 4'h1];
    wire elcl_val_t wr_x = clampv($signed(pwdata), wr_lo, wr_hi);
    wire elcl_val_t cl_lo = (cl_idx == 4'h0) ? xmin_eff : pt_x[cl_idx - 4'h1];
    wire elcl_val_t cl_x = clampv(pt_x[cl_idx], cl_lo, xmax_eff);

    // Elapsed time input
    wire logic time_en = (src_value >= TRUE_LEVEL);
    wire elcl_val_t x_in = (axis_mode == AXIS_TIME) ? elapsed_ms : src_value;

    // Segment search
    logic [3:0] seg;
    logic [3:0] n_last;
    logic found;
    elcl_val_t act_min;
    elcl_val_t act_max;

    always_comb begin
        logic stop;
        stop = 1'b0;
        found = 1'b0;
        seg = 4'h0;
        n_last = 4'h0;
        act_min = pt_y[0];
        act_max = pt_y[0];
        for (int i = 1; i < NPT; i++) begin
            if (!stop) begin
                if (pt_kind[i] == KIND_IGNORE) begin
                    stop = 1'b1;
                end else begin
                    n_last = 4'(i);
                    if (pt_y[i] < act_min) act_min = pt_y[i];
                    if (pt_y[i] > act_max) act_max = pt_y[i];
                    if (!found && x_in <= pt_x[i]) begin
                        found = 1'b1;
                        seg = 4'(i);
                    end
                end
            end
        end
    end

    wire logic [3:0] seg_lo = (seg == 4'h0) ? 4'h0 : seg - 4'h1;
    wire logic below = x_in < pt_x[0];
    wire logic flat = pt_x[seg] == pt_x[seg_lo];
    wire logic direct = below | !found | (pt_kind[seg] == KIND_JUMP) | flat;
    wire elcl_val_t seg_y = below ? pt_y[0] : (found ? pt_y[seg] : pt_y[n_last]);
    wire logic signed [32:0] dx = 33'(x_in) - 33'(pt_x[seg_lo]);
    wire logic signed [32:0] den = 33'(pt_x[seg]) - 33'(pt_x[seg_lo]);
    wire logic signed [32:0] dy = 33'(pt_y[seg]) - 33'(pt_y[seg_lo]);
    wire logic [32:0] dy_mag = dy[32] ? 33'(-dy) : 33'(dy);
    wire logic [63:0] ramp_num = 64'(dx[31:0]) * 64'(dy_mag);
    wire logic signed [33:0] quo_s = $signed({1'b0, div_bus.quo[32:0]});
    wire logic signed [33:0] ramp_res = 34'(y_base) + (ramp_neg ? -quo_s : quo_s);

    // Conditional block
    elcl_val_t arg_m [4];

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            arg_m[k] = arg_sel[k] ? $signed(cond_arg[k]) : '0;
        end
    end

    wire logic cnd1 = cmp_op(op1, arg_m[0], arg_m[1]);
    wire logic cnd2 = cmp_op(op2, arg_m[2], arg_m[3]);
    wire logic cnd_and = cnd1 & cnd2;
    wire logic cnd_xor = cnd1 ^ cnd2;
    wire logic next_cond = (op3 == CMB_AND) ? cnd_and :
        ((op3 == CMB_XOR) ? cnd_xor : (cnd1 | cnd2));

    // Latch thresholds
    wire elcl_val_t set_hi = $signed({16'h0000, set_max});
    wire elcl_val_t set_lo = $signed({16'h0000, set_min});
    wire elcl_val_t rst_hi = $signed({16'h0000, rst_max});
    wire elcl_val_t rst_lo = $signed({16'h0000, rst_min});

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            axis_mode <= AXIS_DATA;
            x_src_math <= 1'b0;
            arg_sel <= '0;
            op1 <= OP_OR;
            op2 <= OP_OR;
            op3 <= CMB_OR;
            set_min <= THR_MIN_RST;
            set_max <= THR_MAX_RST;
            rst_min <= THR_MIN_RST;
            rst_max <= THR_MAX_RST;
        end else if (apb_wr) begin
            if (hit_ctrl) begin
                axis_mode <= pwdata[CTRL_AXIS];
                x_src_math <= pwdata[CTRL_MATH];
                arg_sel <= pwdata[CTRL_SEL_LSB +: 4];
            end
            if (hit_ops) begin
                op1 <= pwdata[OPS_OP1_LSB +: 3];
                op2 <= pwdata[OPS_OP2_LSB +: 3];
                if (wr_op3 <= CMB_XOR) op3 <= wr_op3;
            end
            if (hit_sthr) begin
                set_min <= pwdata[THR_MIN_LSB +: 16];
                set_max <= pwdata[THR_MAX_LSB +: 16];
            end
            if (hit_rthr) begin
                rst_min <= pwdata[THR_MIN_LSB +: 16];
                rst_max <= pwdata[THR_MAX_LSB +: 16];
            end
        end
    end

    // Point storage; a write during the clamp pass wins for its cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NPT; i++) begin
                pt_x[i] <= '0;
                pt_y[i] <= '0;
                pt_kind[i] <= (i == 0) ? KIND_JUMP : KIND_IGNORE;
            end
        end else begin
            if (apb_wr && hit_x) begin
                pt_x[pt_idx] <= wr_x;
            end else if (state == ST_CLAMP && !range_changed) begin
                pt_x[cl_idx] <= cl_x;
            end
            if (apb_wr && hit_y) pt_y[pt_idx] <= $signed(pwdata);
            if (apb_wr && hit_k && pt_idx != 4'h0) pt_kind[pt_idx] <= pwdata[1:0];
        end
    end

    // Read mux
    always_comb begin
        rd_data = '0;
        if (hit_x) rd_data = pt_x[pt_idx];
        else if (hit_y) rd_data = pt_y[pt_idx];
        else if (hit_k) rd_data = {30'h0, pt_kind[pt_idx]};
        else if (hit_ctrl) rd_data = {24'h0, arg_sel, 2'h0, x_src_math, axis_mode};
        else if (hit_ops) rd_data = {22'h0, op3, 1'b0, op2, 1'b0, op1};
        else if (hit_sthr) rd_data = {set_max, set_min};
        else if (hit_rthr) rd_data = {rst_max, rst_min};
        else if (paddr == ADDR_STATUS) rd_data = {29'h0, clamp_hold, cond_out, latch_out};
        else if (paddr == ADDR_TBL_OUT) rd_data = tbl_out;
        else if (paddr == ADDR_TBL_MIN) rd_data = tbl_min;
        else if (paddr == ADDR_TBL_MAX) rd_data = tbl_max;
        else if (paddr == ADDR_ELAPSED) rd_data = elapsed_ms;
    end

    // Wait states only while the x range has changed or x points are being re-clamped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~pready & ~clamp_hold;
            prdata <= rd_data;
            pslverr <= psel & ~pready & ~clamp_hold & ~mapped;
        end
    end

    // Millisecond time base
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt <= '0;
            elapsed_ms <= '0;
        end else if (axis_mode != AXIS_TIME || !time_en) begin
            ms_cnt <= '0;
            elapsed_ms <= '0;
        end else if (ms_cnt == MS_W'(MS_CYCLES_P - 1)) begin
            ms_cnt <= '0;
            if (elapsed_ms < xmax_eff) elapsed_ms <= elapsed_ms + TRUE_LEVEL;
        end else begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end

    // Table engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_FIND;
            cl_idx <= '0;
            rng_lo <= X_LIMIT_MIN;
            rng_hi <= X_LIMIT_MAX;
            tbl_out <= '0;
            tbl_min <= '0;
            tbl_max <= '0;
            y_base <= '0;
            ramp_neg <= 1'b0;
            div_bus.start <= 1'b0;
            div_bus.num <= '0;
            div_bus.den <= '0;
        end else begin
            div_bus.start <= 1'b0;
            tbl_min <= act_min;
            tbl_max <= act_max;
            unique case (state)
                ST_FIND: begin
                    if (range_changed) begin
                        state <= ST_CLAMP;
                        cl_idx <= '0;
                        rng_lo <= xmin_eff;
                        rng_hi <= xmax_eff;
                    end else if (direct) begin
                        tbl_out <= seg_y;
                    end else begin
                        div_bus.start <= 1'b1;
                        div_bus.num <= ramp_num;
                        div_bus.den <= den[31:0];
                        y_base <= pt_y[seg_lo];
                        ramp_neg <= dy[32];
                        state <= ST_DIV;
                    end
                end
                ST_DIV: begin
                    if (div_bus.done) begin
                        tbl_out <= ramp_res[31:0];
                        state <= ST_FIND;
                    end
                end
                ST_CLAMP: begin
                    if (range_changed) begin
                        cl_idx <= '0;
                        rng_lo <= xmin_eff;
                        rng_hi <= xmax_eff;
                    end else if (cl_idx == PT_LAST) begin
                        state <= ST_FIND;
                    end else begin
                        cl_idx <= cl_idx + 4'h1;
                    end
                end
            endcase
        end
    end

    // Conditional block and latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_out <= 1'b0;
            set_on <= 1'b0;
            rst_on <= 1'b0;
            latch_out <= 1'b0;
            rst_seen <= 1'b0;
        end else begin
            rst_seen <= 1'b1;
            cond_out <= next_cond;
            if (set_level >= set_hi) set_on <= 1'b1;
            else if (set_level <= set_lo) set_on <= 1'b0;
            if (reset_level >= rst_hi) rst_on <= 1'b1;
            else if (reset_level <= rst_lo) rst_on <= 1'b0;
            if (rst_on) latch_out <= 1'b0;
            else if (set_on) latch_out <= 1'b1;
        end
    end

    // Checks
    logic x_ordered;

    always_comb begin
        x_ordered = 1'b1;
        for (int i = 1; i < NPT; i++) begin
            if (pt_x[i] < pt_x[i - 1]) x_ordered = 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_latch_rst;
        rst_on |=> !latch_out;
    endproperty
    a_latch_rst: assert property (p_latch_rst) else $error("latch not cleared");

    property p_latch_set;
        set_on && !rst_on |=> latch_out;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set");

    property p_latch_hold;
        !set_on && !rst_on |=> $stable(latch_out);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch lost state");

    property p_thr_band;
        set_level > set_lo && set_level < set_hi |=> set_on == $past(set_on);
    endproperty
    a_thr_band: assert property (p_thr_band) else $error("hysteresis band moved");

    property p_x_order;
        state == ST_FIND && !range_changed && $past(state) == ST_FIND |-> x_ordered;
    endproperty
    a_x_order: assert property (p_x_order) else $error("x points out of order");

    property p_x_range;
        !x_src_math && !clamp_hold |->
            pt_x[0] >= X_LIMIT_MIN && pt_x[PT_LAST] <= X_LIMIT_MAX;
    endproperty
    a_x_range: assert property (p_x_range) else $error("x outside fixed range");

    property p_ops_rst;
        !rst_seen |-> op1 == OP_OR && op2 == OP_OR && op3 == CMB_OR;
    endproperty
    a_ops_rst: assert property (p_ops_rst) else $error("operators not OR at reset");

    property p_xor;
        op3 == CMB_XOR && cnd1 != cnd2 |=> cond_out;
    endproperty
    a_xor: assert property (p_xor) else $error("xor combine wrong");

    property p_below;
        state == ST_FIND && !range_changed && below |=> tbl_out == $past(pt_y[0]);
    endproperty
    a_below: assert property (p_below) else $error("below range not first y");

    property p_kind0;
        pt_kind[0] == KIND_JUMP;
    endproperty
    a_kind0: assert property (p_kind0) else $error("point zero not jump");

    property p_minmax;
        rst_seen |-> tbl_min <= tbl_max;
    endproperty
    a_minmax: assert property (p_minmax) else $error("output min above max");

    c_latch_on: cover property (set_on && !rst_on ##1 latch_out);
    c_ramp_done: cover property (state == ST_DIV && div_bus.done);
    c_time_mode: cover property (axis_mode == AXIS_TIME && elapsed_ms > TRUE_LEVEL);
    c_clamp: cover property (state == ST_CLAMP);
endmodule

// [inc/elcl_pkg.sv]
package elcl_pkg;
    typedef logic signed [31:0] elcl_val_t;
    typedef enum logic [1:0] {ST_FIND, ST_DIV, ST_CLAMP} elcl_state_e;

    // Table geometry
    localparam int NPT = 11;
    localparam logic [3:0] PT_LAST = 4'ha;
    localparam logic [1:0] KIND_IGNORE = 2'h0;
    localparam logic [1:0] KIND_RAMP = 2'h1;
    localparam logic [1:0] KIND_JUMP = 2'h2;
    localparam logic AXIS_DATA = 1'b0;
    localparam logic AXIS_TIME = 1'b1;
    localparam elcl_val_t X_LIMIT_MIN = -32'sd100000;
    localparam elcl_val_t X_LIMIT_MAX = 32'sd1000000;
    localparam elcl_val_t TRUE_LEVEL = 32'sh1;

    // Condition operators
    localparam logic [2:0] OP_EQ = 3'h0;
    localparam logic [2:0] OP_NE = 3'h1;
    localparam logic [2:0] OP_GT = 3'h2;
    localparam logic [2:0] OP_GE = 3'h3;
    localparam logic [2:0] OP_LT = 3'h4;
    localparam logic [2:0] OP_LE = 3'h5;
    localparam logic [2:0] OP_OR = 3'h6;
    localparam logic [2:0] OP_AND = 3'h7;
    localparam logic [1:0] CMB_OR = 2'h0;
    localparam logic [1:0] CMB_AND = 2'h1;
    localparam logic [1:0] CMB_XOR = 2'h2;

    // Register map
    localparam int APB_AW = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OPS = 8'h04;
    localparam logic [7:0] ADDR_SET_THR = 8'h08;
    localparam logic [7:0] ADDR_RST_THR = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_TBL_OUT = 8'h14;
    localparam logic [7:0] ADDR_TBL_MIN = 8'h18;
    localparam logic [7:0] ADDR_TBL_MAX = 8'h1c;
    localparam logic [7:0] ADDR_ELAPSED = 8'h20;
    localparam logic [1:0] REG_X = 2'h1;
    localparam logic [1:0] REG_Y = 2'h2;
    localparam logic [1:0] REG_K = 2'h3;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 5;
    localparam int REG_LSB = 6;
    localparam int REG_MSB = 7;
    localparam int CTRL_AXIS = 0;
    localparam int CTRL_MATH = 1;
    localparam int CTRL_SEL_LSB = 4;
    localparam int OPS_OP1_LSB = 0;
    localparam int OPS_OP2_LSB = 4;
    localparam int OPS_OP3_LSB = 8;
    localparam int THR_MIN_LSB = 0;
    localparam int THR_MAX_LSB = 16;
    localparam int ST_LATCH = 0;
    localparam int ST_COND = 1;
    localparam int ST_BUSY = 2;
    localparam logic [15:0] THR_MIN_RST = 16'h0000;
    localparam logic [15:0] THR_MAX_RST = 16'h0064;

    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int DIV_STEPS = 64;
    localparam int DIV_CNT_W = 7;

    function automatic elcl_val_t clampv(elcl_val_t v, elcl_val_t lo, elcl_val_t hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic cmp_op(logic [2:0] op, elcl_val_t a, elcl_val_t b);
        logic ta;
        logic tb;
        ta = (a >= TRUE_LEVEL);
        tb = (b >= TRUE_LEVEL);
        case (op)
            OP_EQ: return a == b;
            OP_NE: return a != b;
            OP_GT: return a > b;
            OP_GE: return a >= b;
            OP_LT: return a < b;
            OP_LE: return a <= b;
            OP_OR: return ta | tb;
            default: return ta & tb;
        endcase
    endfunction
endpackage

// [inc/elcl_div_if.sv]
`timescale 1ns/100ps
interface elcl_div_if;
    logic start;
    logic [63:0] num;
    logic [31:0] den;
    logic done;
    logic [63:0] quo;
    modport req (output start, output num, output den, input done, input quo);
    modport srv (input start, input num, input den, output done, output quo);
endinterface

// [src/elcl_div.sv]
`timescale 1ns/100ps
module elcl_div (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Divide request
    elcl_div_if.srv bus
);
    import elcl_pkg::*;

    localparam int DIV_LAT_MAX = 65;

    logic [63:0] q;
    logic [31:0] r;
    logic [DIV_CNT_W-1:0] cnt;

    // Restoring divide, one quotient bit per clock
    wire logic [32:0] r_sh = {r, q[63]};
    wire logic fits = r_sh >= {1'b0, bus.den};

    assign bus.quo = q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            r <= '0;
            cnt <= '0;
            bus.done <= 1'b0;
        end else begin
            bus.done <= 1'b0;
            if (bus.start) begin
                q <= bus.num;
                r <= '0;
                cnt <= DIV_CNT_W'(DIV_STEPS);
            end else if (cnt != '0) begin
                q <= {q[62:0], fits};
                r <= fits ? 32'(r_sh - {1'b0, bus.den}) : r_sh[31:0];
                cnt <= cnt - 1'b1;
                bus.done <= (cnt == DIV_CNT_W'(1));
            end
        end
    end

    property p_div_bound;
        @(posedge pclk) disable iff (!presetn)
        bus.start |-> ##[1:DIV_LAT_MAX] bus.done;
    endproperty
    a_div_bound: assert property (p_div_bound) else $error("divide did not finish");
endmodule

// [dv/elcl_src_model.sv]
`timescale 1ns/100ps
module elcl_src_model (
    // Clock
    input wire logic pclk,
    // Values asked for
    input wire elcl_pkg::elcl_val_t req_x,
    input wire logic [3:0][31:0] req_arg,
    input wire elcl_pkg::elcl_val_t req_set,
    input wire elcl_pkg::elcl_val_t req_rst,
    // Source outputs
    output elcl_pkg::elcl_val_t src_value,
    output logic [3:0][31:0] cond_arg,
    output elcl_pkg::elcl_val_t set_level,
    output elcl_pkg::elcl_val_t reset_level
);
    import elcl_pkg::*;
    // Upstream blocks update on the clock, one cycle late
    always_ff @(posedge pclk) begin
        src_value <= req_x;
        cond_arg <= req_arg;
        set_level <= req_set;
        reset_level <= req_rst;
    end
endmodule

// [dv/elcl_top_tb.sv]
`timescale 1ns/100ps
module elcl_top_tb;
    import elcl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, cond_out, latch_out;
    elcl_val_t x = 0, s = 0, r = 0, tbl_out, tbl_min, tbl_max;
    elcl_val_t src_value, set_level, reset_level;
    logic [3:0][31:0] a = '0, cond_arg;
    int mismatches = 0, checks = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    elcl_src_model src (.pclk(pclk), .req_x(x), .req_arg(a), .req_set(s), .req_rst(r),
        .src_value(src_value), .cond_arg(cond_arg), .set_level(set_level),
        .reset_level(reset_level));
    elcl_top #(.MS_CYCLES_P(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_value(src_value),
        .math_min(32'sd0), .math_max(32'sd1000), .cond_arg(cond_arg),
        .set_level(set_level), .reset_level(reset_level), .tbl_out(tbl_out),
        .tbl_min(tbl_min), .tbl_max(tbl_max), .cond_out(cond_out), .latch_out(latch_out));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Holds the request until pready is seen, then idles one cycle
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_reset;
        chk("latch0", 32'h0, latch_out);
        apb(0, ADDR_OPS, 0);
        chk("ops", 32'h66, rd);
        apb(1, 8'hc0, 32'h1);
        apb(0, 8'hc0, 0);
        chk("kind0", 32'h2, rd);
        apb(0, 8'h6c, 0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask
    task automatic t_table;
        elcl_val_t px[4] = '{-5, 50, 150, 500};
        elcl_val_t pe[4] = '{10, 20, 40, 60};
        for (int i = 10; i >= 2; i--)
            apb(1, 8'h40 + 8'(4 * i), 32'd200);
        apb(1, 8'h44, 32'd100);
        apb(1, 8'h80, 32'd10);
        apb(1, 8'h84, 32'd20);
        apb(1, 8'h88, 32'd60);
        apb(1, 8'hc4, 32'h2);
        apb(1, 8'hc8, 32'h1);
        for (int i = 0; i < 4; i++) begin
            x <= px[i];
            repeat (150) @(posedge pclk);
            chk("tbl_out", pe[i], tbl_out);
        end
        chk("tbl_min", 32'd10, tbl_min);
        chk("tbl_max", 32'd60, tbl_max);
        apb(1, 8'hc4, 32'h0);
        repeat (150) @(posedge pclk);
        chk("ignored", 32'd10, tbl_out);
        chk("max_ign", 32'd10, tbl_max);
        apb(1, 8'h40, 32'd300);
        apb(0, 8'h40, 0);
        chk("x0_clamp", 32'd100, rd);
        apb(1, 8'h68, 32'd2000000);
        apb(0, 8'h68, 0);
        chk("x10_clamp", 32'd1000000, rd);
        apb(1, ADDR_CTRL, 32'h2);
        repeat (20) @(posedge pclk);
        apb(0, 8'h68, 0);
        chk("x10_math", 32'd1000, rd);
        $display("test table done");
    endtask
    task automatic t_cond;
        int pa[3] = '{3, 5, 0};
        int pb[3] = '{5, 3, 5};
        logic [7:0] pm[3] = '{8'hf2, 8'hce, 8'h72};
        apb(1, ADDR_CTRL, 32'hf0);
        for (int j = 0; j < 3; j++)
            for (int k = 0; k < 8; k++) begin
                a <= {32'h0, 32'h0, 32'(pb[j]), 32'(pa[j])};
                apb(1, ADDR_OPS, 32'h60 | 32'(k));
                repeat (3) @(posedge pclk);
                chk("cond1", {31'h0, pm[j][k]}, cond_out);
            end
        for (int k = 0; k < 6; k++) begin
            a <= {32'h0, 32'(k % 2), 32'h0, 32'h1};
            apb(1, ADDR_OPS, 32'((k / 2) << 8) | 32'h66);
            repeat (3) @(posedge pclk);
            chk("comb", (k < 2) ? 1 : (k < 4) ? k % 2 : 1 - k % 2, cond_out);
        end
        apb(1, ADDR_OPS, 32'h366);
        apb(0, ADDR_OPS, 0);
        chk("op3_keep", 32'h266, rd);
        a <= {32'h0, 32'h0, 32'h0, 32'h1};
        apb(1, ADDR_OPS, 32'h66);
        apb(1, ADDR_CTRL, 32'he0);
        repeat (3) @(posedge pclk);
        chk("unselected", 32'h0, cond_out);
        $display("test cond done");
    endtask
    task automatic t_latch;
        int ls[7] = '{90, 50, 50, 90, 90, 90, 10};
        int lr[7] = '{0, 0, 90, 90, 50, 10, 10};
        logic [6:0] le = 7'b1100011;
        apb(1, ADDR_SET_THR, 32'h00500014);
        apb(1, ADDR_RST_THR, 32'h00500014);
        for (int i = 0; i < 7; i++) begin
            s <= ls[i];
            r <= lr[i];
            repeat (4) @(posedge pclk);
            chk("latch", {31'h0, le[i]}, latch_out);
        end
        $display("test latch done");
    endtask
    task automatic t_time;
        x <= 0;
        apb(1, ADDR_CTRL, 32'h1);
        repeat (10) @(posedge pclk);
        apb(0, ADDR_ELAPSED, 0);
        chk("elapsed0", 32'h0, rd);
        x <= 1;
        repeat (40) @(posedge pclk);
        apb(0, ADDR_ELAPSED, 0);
        chk("elapsed", 32'h1, {31'h0, rd > 32'd5 && rd < 32'd12});
        $display("test time done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Whole run needs a little over a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_table();
        t_cond();
        t_latch();
        t_time();
        end_of_test();
    end
endmodule
